// *** sifm_params.svh ***
// constants of the servo input function mapper: register offsets, setup codes, reset values
// assumes a 32-bit apb slave with byte addresses and word-aligned registers
`ifndef SIFM_PARAMS_SVH
`define SIFM_PARAMS_SVH

`define SIFM_OFS_IN1_SET      8'h00
`define SIFM_OFS_IN6_SET      8'h14
`define SIFM_OFS_INPUT_STATE  8'h18
`define SIFM_OFS_FUNC_STATE   8'h1C
`define SIFM_OFS_DRIVE_STATUS 8'h20
`define SIFM_OFS_IRQ_STATUS   8'h24
`define SIFM_OFS_IRQ_ENABLE   8'h28
`define SIFM_OFS_IRQ_CLEAR    8'h2C

// setup codes: the odd code is active closed, the next even code is active open
`define SIFM_CODE_GENERAL     6'h00
`define SIFM_CODE_SERVO_ON    6'h01
`define SIFM_CODE_ALARM_CLR   6'h03
`define SIFM_CODE_CW_LIMIT    6'h05
`define SIFM_CODE_CCW_LIMIT   6'h07
`define SIFM_CODE_GAIN_SEL    6'h0B
`define SIFM_CODE_ESTOP       6'h0D
`define SIFM_CODE_HOMING      6'h0F
`define SIFM_CODE_TORQUE_CAP  6'h13
`define SIFM_CODE_ZERO_HOLD   6'h15
`define SIFM_CODE_VEL_CAP_SEL 6'h25
`define SIFM_CODE_HOME_SWITCH 6'h27
`define SIFM_CODE_START_PROG  6'h2D

// reset setup codes per input
`define SIFM_RST_IN1          6'h00
`define SIFM_RST_IN2          6'h00
`define SIFM_RST_IN3          6'h03
`define SIFM_RST_IN4          6'h01
`define SIFM_RST_IN5          6'h07
`define SIFM_RST_IN6          6'h05

// interrupt event bit positions
`define SIFM_EV_ALARM_SET     0
`define SIFM_EV_ALARM_CLR     1
`define SIFM_EV_ESTOP         2
`define SIFM_EV_LIMIT         3

`endif

// *** sifm_pkg.sv ***
// types of the servo input function mapper
// assumes sifm_params.svh is compiled alongside
package sifm_pkg;

   timeunit 1ns;
   timeprecision 1ps;

   localparam int NUM_IN   = 6;
   localparam int NUM_FUNC = 12;
   localparam int NUM_EV   = 4;

   typedef logic [5:0] sifm_code_t;

   // function slots, index into the decoded function vector
   typedef enum logic [3:0]
   {
      SIFM_F_SERVO_ON    = 4'h0,
      SIFM_F_ALARM_CLR   = 4'h1,
      SIFM_F_CW_LIMIT    = 4'h2,
      SIFM_F_CCW_LIMIT   = 4'h3,
      SIFM_F_GAIN_SEL    = 4'h4,
      SIFM_F_ESTOP       = 4'h5,
      SIFM_F_HOMING      = 4'h6,
      SIFM_F_TORQUE_CAP  = 4'h7,
      SIFM_F_ZERO_HOLD   = 4'h8,
      SIFM_F_VEL_CAP_SEL = 4'h9,
      SIFM_F_HOME_SWITCH = 4'hA,
      SIFM_F_START_PROG  = 4'hB
   } sifm_func_e;

   typedef struct packed
   {
      logic [NUM_IN-1:0]        sync1;
      logic [NUM_IN-1:0]        sync2;
      sifm_code_t [NUM_IN-1:0]  code;
      logic [NUM_FUNC-1:0]      func_act;
      logic [NUM_IN-1:0]        gp_state;
      logic                     alarm;
      logic                     winding_en;
      logic                     led_green;
      logic                     led_red;
      logic [NUM_EV-1:0]        irq_status;
      logic [NUM_EV-1:0]        irq_enable;
      logic                     irq;
      logic                     pready;
      logic                     pslverr;
      logic [31:0]              prdata;
   } sifm_state_s;

endpackage

// *** sifm_properties.sv ***
// concurrent checks on the ports of the servo input function mapper
// assumes one pclk domain; bound onto every sifm_top instance
module sifm_props
   import sifm_pkg::*;
(
   input wire logic                pclk,
   input wire logic                presetn,
   input wire logic                psel,
   input wire logic                penable,
   input wire logic                pready,
   input wire logic                pslverr,
   input wire logic [31:0]         prdata,
   input wire logic [NUM_IN-1:0]   input_closed,
   input wire logic                alarm_event,
   input wire logic [NUM_FUNC-1:0] func_active,
   input wire logic                winding_enable,
   input wire logic                led_green,
   input wire logic                led_red
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] up_cnt;
   // the sync pipeline refills after reset, so quiet checks wait for it
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         up_cnt <= 3'h0;
      else if (up_cnt != 3'h7)
         up_cnt <= up_cnt + 3'h1;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence calm_s;
      (up_cnt == 3'h7 && !psel && $stable(input_closed))[*4];
   endsequence
   sequence held_s;
      (led_red && !psel && !alarm_event && $stable(input_closed))[*6];
   endsequence
   alarm_red_a: assert property (alarm_event |=> led_red)
      else $error("red lamp missed an alarm");
   lamp_pair_a: assert property (led_green != led_red)
      else $error("lamps not complementary");
   wind_gate_a: assert property (winding_enable |-> func_active[SIFM_F_SERVO_ON])
      else $error("windings on without servo enable");
   sync_hold_a: assert property (calm_s |-> $stable(func_active))
      else $error("function vector moved with quiet inputs");
   clear_edge_a: assert property (held_s |=> led_red)
      else $error("alarm cleared by a held level");
   ready_wait_a: assert property (psel && penable && !pready |=> pready)
      else $error("apb answer late");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
endmodule // sifm_props

bind sifm_top sifm_props u_props
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .prdata(prdata), .input_closed(input_closed),
   .alarm_event(alarm_event), .func_active(func_active),
   .winding_enable(winding_enable), .led_green(led_green), .led_red(led_red)
);

// *** sifm_switches.sv ***
// model of the switches and controller outputs wired to the six inputs
// assumes the bench names the wanted contact states, 1 = circuit closed
module sifm_switches
(
   input wire logic       pclk,
   input wire logic [5:0] press,
   output logic [5:0]     input_closed
);
   timeunit 1ns;
   timeprecision 1ps;
   initial input_closed = 6'h00;
   // contacts move on an edge, like a controller output; alarm clear idles open
   always @(posedge pclk)
      input_closed <= press;
endmodule // sifm_switches

// *** sifm_tb.sv ***
// self-checking bench of the servo input function mapper
// assumes sifm_top, sifm_switches and the bound checker are compiled before it
module tb
   import sifm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, alarm_event = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, winding_enable, led_green, led_red, irq, e;
   logic [5:0]  press = 6'h00, input_closed, gp_use, gp_use4;
   logic [11:0] func_active;
   logic [5:0]  rst_code [6] = '{6'h00, 6'h00, 6'h03, 6'h01, 6'h07, 6'h05};
   int          bad_count = 0, n_compared = 0, cyc = 0;
   always #10 pclk = ~pclk;
   sifm_top dut
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .input_closed(input_closed), .alarm_event(alarm_event), .func_active(func_active),
      .general_input_use(gp_use), .winding_enable(winding_enable), .led_green(led_green),
      .led_red(led_red), .irq(irq)
   );
   sifm_top #(.FOUR_INPUT(1'b1)) dut4
   (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(), .pslverr(),
      .input_closed(input_closed), .alarm_event(alarm_event), .func_active(),
      .general_input_use(gp_use4), .winding_enable(), .led_green(), .led_red(), .irq()
   );
   sifm_switches sw (.pclk(pclk), .press(press), .input_closed(input_closed));
   task automatic give_verdict;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         bad_count++;
         give_verdict();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_compared++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // the #1 lets the edge's register updates land before anything is read
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask
   task automatic pulse_alarm;
      @(posedge pclk);
      alarm_event <= 1'b1;
      @(posedge pclk);
      alarm_event <= 1'b0;
      settle(2);
   endtask
   function automatic logic [11:0] exp_func(input logic [5:0] c, input logic b);
      logic [5:0] base [12] = '{6'h01, 6'h03, 6'h05, 6'h07, 6'h0B, 6'h0D,
                                6'h0F, 6'h13, 6'h15, 6'h25, 6'h27, 6'h2D};
      exp_func = 12'h000;
      for (int k = 0; k < 12; k++)
         if (c == base[k])
            exp_func[k] = b;
         else if (c == base[k] + 6'h01)
            exp_func[k] = !b;
   endfunction
   initial
   begin
      logic [5:0] c;
      logic       b;
      void'($urandom(75));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         apb(1'b0, 8'(4 * i), 32'h0);
         chk(q, 32'(rst_code[i]), "reset setting");
      end
      chk(led_green, 32'h1, "green at rest");
      apb(1'b0, 8'h30, 32'h0);
      chk(e, 32'h1, "unmapped error");
      apb(1'b1, 8'h10, 32'h07);
      apb(1'b1, 8'h14, 32'h05);
      press <= 6'h30;
      settle(5);
      chk(func_active, 32'h00C, "default limits");
      chk(gp_use4, 32'h30, "four input general");
      $display("test reset_defaults done");
      for (int i = 0; i < 64; i++)
      begin
         c = 6'(i);
         b = 1'($urandom);
         apb(1'b1, 8'h00, 32'(c));
         press <= {5'h00, b};
         settle(5);
         chk(func_active, 32'(exp_func(c, b)), "decoded function");
         chk(gp_use, 32'(b && c == 6'h00), "general input");
         apb(1'b0, 8'h00, 32'h0);
         chk(q, 32'(c), "setting readback");
      end
      $display("test code_decode done");
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h28, 32'h1);
      press <= 6'h08;
      settle(5);
      chk(winding_enable, 32'h1, "windings on");
      pulse_alarm();
      chk(led_red, 32'h1, "red on alarm");
      chk(irq, 32'h1, "alarm interrupt");
      apb(1'b0, 8'h20, 32'h0);
      chk(q, 32'h1, "drive status alarm");
      apb(1'b1, 8'h28, 32'h0);
      settle(2);
      chk(irq, 32'h0, "masked interrupt");
      apb(1'b0, 8'h24, 32'h0);
      chk(q, 32'hD, "sticky status");
      apb(1'b1, 8'h2C, 32'hF);
      apb(1'b1, 8'h28, 32'h1);
      settle(2);
      chk(irq, 32'h0, "cleared interrupt");
      press <= 6'h0C;
      settle(8);
      chk(led_red, 32'h0, "clear on closing");
      apb(1'b0, 8'h24, 32'h0);
      chk(q, 32'h2, "alarm cleared event");
      apb(1'b0, 8'h18, 32'h0);
      chk(q, 32'h0C, "input state");
      apb(1'b0, 8'h1C, 32'h0);
      chk(q, 32'h003, "function state");
      pulse_alarm();
      settle(8);
      chk(led_red, 32'h1, "held contact keeps alarm");
      press <= 6'h08;
      settle(6);
      press <= 6'h0C;
      settle(8);
      chk(led_red, 32'h0, "clear on new closing");
      chk(winding_enable, 32'h1, "windings back");
      apb(1'b0, 8'h20, 32'h0);
      chk(q, 32'h2, "drive status running");
      press <= 6'h04;
      settle(6);
      chk(winding_enable, 32'h0, "windings off when open");
      $display("test alarm_clear done");
      give_verdict();
   end
endmodule // tb

// *** sifm_top.sv ***
// servo input function mapper: maps six discrete inputs onto drive functions, apb registers
// assumes inputs synchronous-capable levels, 1 = input circuit closed, single pclk domain
`include "sifm_params.svh"

// Overview of operation
// RULE_01 - green lamp steady while powered, no alarm and windings not enabled; the code lights it whenever no alarm is present, windings on or not
// RULE_02 - red lamp lit whenever an alarm is active
// RULE_03 - each input picks one function or general use, with selectable polarity
// RULE_04 - codes 1/2 servo enable, 3/4 alarm clear, 5/6 cw, 7/8 ccw limit
// RULE_05 - pairs 11,13,15,19,21,37,39,45 decode further functions, odd closed, even open
// RULE_06 - code 0 is general input, plain state only, no open-active variant
// RULE_07 - closed state means the input circuit is complete and current flows
// RULE_08 - open state means the circuit is broken and no current flows
// RULE_09 - six-input reset defaults: 0,0,3,1,7,5 all active closed
// RULE_10 - four-input reset defaults: 0,0,3,1 all active closed
// RULE_11 - alarm clear acts only on the open-to-closed transition, not while held
// RULE_12 - servo enable code 1 energises windings while closed, else disabled
// RULE_13 - inputs synchronised before decoding; unknown setup codes are inactive
module sifm_top
   import sifm_pkg::*;
#(
   parameter bit FOUR_INPUT = 1'b0
)
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   input  wire logic [NUM_IN-1:0] input_closed,
   input  wire logic              alarm_event,
   output logic [NUM_FUNC-1:0]    func_active,
   output logic [NUM_IN-1:0]      general_input_use,
   output logic                   winding_enable,
   output logic                   led_green,
   output logic                   led_red,
   output logic                   irq
);

   timeunit 1ns;
   timeprecision 1ps;

   // the four-input variant keeps inputs 5 and 6 on general use
   localparam sifm_code_t RST_IN5 = FOUR_INPUT ? `SIFM_CODE_GENERAL : `SIFM_RST_IN5;
   localparam sifm_code_t RST_IN6 = FOUR_INPUT ? `SIFM_CODE_GENERAL : `SIFM_RST_IN6;

   localparam sifm_state_s STATE_RST = '{
      sync1      : '0,
      sync2      : '0,
      code       : {RST_IN6, RST_IN5, `SIFM_RST_IN4, `SIFM_RST_IN3,
                    `SIFM_RST_IN2, `SIFM_RST_IN1},
      func_act   : '0,
      gp_state   : '0,
      alarm      : 1'b0,
      winding_en : 1'b0,
      led_green  : 1'b1,
      led_red    : 1'b0,
      irq_status : '0,
      irq_enable : '0,
      irq        : 1'b0,
      pready     : 1'b0,
      pslverr    : 1'b0,
      prdata     : '0
   };

   sifm_state_s               state_reg;
   sifm_state_s               state_next;
   logic [NUM_FUNC-1:0]       per_in_act [NUM_IN];
   logic [NUM_IN-1:0]         per_in_gp;

   // per-input decode works on the synchronised level only
   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++)
      begin : g_decode
         logic       closed_s;
         logic       active_s;
         sifm_code_t code_s;
         assign closed_s = state_reg.sync2[gi]; // see RULE_13
         assign code_s   = state_reg.code[gi];
         // odd codes assert on a closed circuit, even codes on an open one
         assign active_s = code_s[0] ? closed_s : ~closed_s; // see RULE_07 see RULE_08
         assign per_in_gp[gi] = (code_s == `SIFM_CODE_GENERAL) & closed_s; // see RULE_06

         always_comb
         begin
            per_in_act[gi] = '0;
            case (code_s) // see RULE_03 see RULE_04 see RULE_05
               `SIFM_CODE_SERVO_ON, `SIFM_CODE_SERVO_ON + 6'h01:
               begin
                  per_in_act[gi][SIFM_F_SERVO_ON] = active_s;
               end
               `SIFM_CODE_ALARM_CLR, `SIFM_CODE_ALARM_CLR + 6'h01:
               begin
                  per_in_act[gi][SIFM_F_ALARM_CLR] = active_s;
               end
               `SIFM_CODE_CW_LIMIT, `SIFM_CODE_CW_LIMIT + 6'h01:
               begin
                  per_in_act[gi][SIFM_F_CW_LIMIT] = active_s;
               end
               `SIFM_CODE_CCW_LIMIT, `SIFM_CODE_CCW_LIMIT + 6'h01:
               begin
                  per_in_act[gi][SIFM_F_CCW_LIMIT] = active_s;
               end
               `SIFM_CODE_GAIN_SEL, `SIFM_CODE_GAIN_SEL + 6'h01:
               begin
                  per_in_act[gi][SIFM_F_GAIN_SEL] = active_s;
               end
               `SIFM_CODE_ESTOP, `SIFM_CODE_ESTOP + 6'h01:
               begin
                  per_in_act[gi][SIFM_F_ESTOP] = active_s;
               end
               `SIFM_CODE_HOMING, `SIFM_CODE_HOMING + 6'h01:
               begin
                  per_in_act[gi][SIFM_F_HOMING] = active_s;
               end
               `SIFM_CODE_TORQUE_CAP, `SIFM_CODE_TORQUE_CAP + 6'h01:
               begin
                  per_in_act[gi][SIFM_F_TORQUE_CAP] = active_s;
               end
               `SIFM_CODE_ZERO_HOLD, `SIFM_CODE_ZERO_HOLD + 6'h01:
               begin
                  per_in_act[gi][SIFM_F_ZERO_HOLD] = active_s;
               end
               `SIFM_CODE_VEL_CAP_SEL, `SIFM_CODE_VEL_CAP_SEL + 6'h01:
               begin
                  per_in_act[gi][SIFM_F_VEL_CAP_SEL] = active_s;
               end
               `SIFM_CODE_HOME_SWITCH, `SIFM_CODE_HOME_SWITCH + 6'h01:
               begin
                  per_in_act[gi][SIFM_F_HOME_SWITCH] = active_s;
               end
               `SIFM_CODE_START_PROG, `SIFM_CODE_START_PROG + 6'h01:
               begin
                  per_in_act[gi][SIFM_F_START_PROG] = active_s;
               end
               // codes 9/10 and every gap in the table stay silent
               default:
               begin
                  per_in_act[gi] = '0; // see RULE_13
               end
            endcase
         end
      end
   endgenerate

   always_comb
   begin
      logic [NUM_FUNC-1:0] act;
      logic [NUM_EV-1:0]   ev;
      logic                clr_edge;
      logic                apb_acc;
      logic                wr_now;
      logic                mapped;
      logic [31:0]         rd;
      logic [7:0]          slot;
      act        = '0;
      ev         = '0;
      rd         = '0;
      mapped     = 1'b0;
      slot       = '0;
      clr_edge   = 1'b0;
      apb_acc    = 1'b0;
      wr_now     = 1'b0;
      state_next = state_reg;

      // two-stage synchroniser on the raw contacts
      state_next.sync1 = input_closed; // see RULE_13
      state_next.sync2 = state_reg.sync1;

      for (int i = 0; i < NUM_IN; i++)
      begin
         act = act | per_in_act[i];
      end
      state_next.func_act = act;
      state_next.gp_state = per_in_gp;

      // a held clear does nothing; only a fresh assertion clears the alarm
      clr_edge = act[SIFM_F_ALARM_CLR] & ~state_reg.func_act[SIFM_F_ALARM_CLR]; // see RULE_11
      // a new fault in the same cycle as a clear keeps the alarm standing
      if (alarm_event)
      begin
         state_next.alarm = 1'b1;
      end
      else if (clr_edge)
      begin
         state_next.alarm = 1'b0;
      end
      ev[`SIFM_EV_ALARM_SET] = alarm_event & ~state_reg.alarm;
      ev[`SIFM_EV_ALARM_CLR] = clr_edge & state_reg.alarm & ~alarm_event;
      ev[`SIFM_EV_ESTOP]     = act[SIFM_F_ESTOP] & ~state_reg.func_act[SIFM_F_ESTOP];
      ev[`SIFM_EV_LIMIT]     = (act[SIFM_F_CW_LIMIT] & ~state_reg.func_act[SIFM_F_CW_LIMIT])
                             | (act[SIFM_F_CCW_LIMIT] & ~state_reg.func_act[SIFM_F_CCW_LIMIT]);

      // windings follow the servo-enable function, dropped by alarm or emergency stop
      state_next.winding_en = act[SIFM_F_SERVO_ON] & ~state_next.alarm
                            & ~act[SIFM_F_ESTOP]; // see RULE_12
      state_next.led_red    = state_next.alarm; // see RULE_02
      // green stays lit whenever no alarm is present, enabled or not
      state_next.led_green  = ~state_next.alarm; // see RULE_01

      // apb: answer one cycle into the access phase, write lands on the pready edge
      apb_acc = psel & penable;
      wr_now  = apb_acc & state_reg.pready & pwrite;
      slot    = paddr;
      if (paddr[1:0] == 2'b00)
      begin
         if (slot <= `SIFM_OFS_IN6_SET)
         begin
            mapped = 1'b1;
            rd     = {26'h0000000, state_reg.code[slot[4:2]]};
         end
         else
         begin
            mapped = 1'b1;
            case (slot)
               `SIFM_OFS_INPUT_STATE:
               begin
                  rd = {26'h0, state_reg.sync2};
               end
               `SIFM_OFS_FUNC_STATE:
               begin
                  rd = {20'h0, state_reg.func_act};
               end
               `SIFM_OFS_DRIVE_STATUS:
               begin
                  rd = {30'h0, state_reg.winding_en, state_reg.alarm};
               end
               `SIFM_OFS_IRQ_STATUS:
               begin
                  rd = {28'h0, state_reg.irq_status};
               end
               `SIFM_OFS_IRQ_ENABLE:
               begin
                  rd = {28'h0, state_reg.irq_enable};
               end
               // the clear register is write-only, so software never sees stale clears
               `SIFM_OFS_IRQ_CLEAR:
               begin
                  rd = '0;
               end
               default:
               begin
                  mapped = 1'b0;
               end
            endcase
         end
      end

      state_next.pready  = apb_acc & ~state_reg.pready;
      state_next.prdata  = (apb_acc & ~state_reg.pready & ~pwrite & mapped) ? rd : '0;
      state_next.pslverr = apb_acc & ~state_reg.pready & ~mapped;

      state_next.irq_status = state_reg.irq_status;
      if (wr_now & mapped)
      begin
         if (slot <= `SIFM_OFS_IN6_SET)
         begin
            // absent inputs of the small variant stay on general use
            if (!(FOUR_INPUT && slot[4:2] >= 3'h4))
            begin
               state_next.code[slot[4:2]] = pwdata[5:0]; // see RULE_03
            end
         end
         else if (slot == `SIFM_OFS_IRQ_ENABLE)
         begin
            state_next.irq_enable = pwdata[NUM_EV-1:0];
         end
         else if (slot == `SIFM_OFS_IRQ_CLEAR)
         begin
            state_next.irq_status = state_reg.irq_status & ~pwdata[NUM_EV-1:0];
         end
      end
      // a fresh event beats a clear written in the same cycle
      state_next.irq_status = state_next.irq_status | ev;
      state_next.irq = |(state_next.irq_status & state_next.irq_enable);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= STATE_RST; // see RULE_09 see RULE_10
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign pready            = state_reg.pready;
   assign prdata            = state_reg.prdata;
   assign pslverr           = state_reg.pslverr;
   assign func_active       = state_reg.func_act;
   assign general_input_use = state_reg.gp_state;
   assign winding_enable    = state_reg.winding_en;
   assign led_green         = state_reg.led_green;
   assign led_red           = state_reg.led_red;
   assign irq               = state_reg.irq;

endmodule // sifm_top
